// File: pkg/chan_meas_if.sv
// Carrier between the register bank and one channel current result.
`timescale 1ns/100ps
interface chan_meas_if;
	logic chanOn;
	logic detClassEn;
	logic portDisable;
	logic curValid;
	logic [13:0] curCount;
	logic classValid;
	logic [13:0] classCount;
	logic [13:0] result;
	logic classScale;
	logic shutdown;

	modport chan (
		input chanOn,
		input detClassEn,
		input portDisable,
		input curValid,
		input curCount,
		input classValid,
		input classCount,
		output result,
		output classScale,
		output shutdown
	);

	modport bank (
		output chanOn,
		output detClassEn,
		output portDisable,
		output curValid,
		output curCount,
		output classValid,
		output classCount,
		input result,
		input classScale,
		input shutdown
	);
endinterface

// File: pkg/telemetry_params.svh
// Constants of the port telemetry result registers.
`ifndef TELEMETRY_PARAMS_SVH
`define TELEMETRY_PARAMS_SVH

// ----------------------------------------------------------------------
// Result coding
// ----------------------------------------------------------------------
`define RES_WIDTH 14
`define RES_MSB 13
`define RES_ZERO 14'h0000
`define BYTE_ZERO 8'h00
`define HIGH_PAD 2'h0
`define LOW_BYTE_MSB 7
`define HIGH_BYTE_LSB 8
`define CHAN_COUNT 4
`define LIMIT_COUNT_DEFAULT 14'h3FFF

// ----------------------------------------------------------------------
// Management command codes
// ----------------------------------------------------------------------
`define CMD_SUPPLY_VOLTAGE 8'h2E
`define CMD_CHAN1_CURRENT 8'h30
`define CMD_CHAN1_VOLTAGE 8'h32
`define CMD_CHAN2_CURRENT 8'h34
`define CMD_CHAN3_CURRENT 8'h38
`define CMD_CHAN4_CURRENT 8'h3C
`define CMD_CURRENT_STRIDE 8'h04

`endif

// File: pkg/telemetry_pkg.sv
// Types shared by the port telemetry result registers.
package telemetry_pkg;

	typedef enum logic [1:0] {
		IDLE_S,
		CLASS_S,
		POWER_S
	} chan_state_t;

	typedef enum logic {
		LOW_SEL,
		HIGH_SEL
	} byte_sel_t;

endpackage

// File: testbench/port_telemetry_registers_checker.sv
// Concurrent checks on the telemetry register ports.
`timescale 1ns/100ps
module port_telemetry_checker
	import telemetry_pkg::*;
#(
	parameter int NCH = 4,
	parameter logic [13:0] LIMIT_COUNT = 14'h3FFF
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cmdValid,
	input wire logic rdReq,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire logic [NCH-1:0] chanOn,
	input wire logic [NCH-1:0] portDisable,
	input wire logic [NCH-1:0] curValid,
	input wire logic [NCH*14-1:0] curCount,
	input wire logic [NCH-1:0] classValid,
	input wire logic [NCH-1:0] classScale,
	input wire logic [NCH-1:0] chanShutdown
);
	wire overLimit = chanOn[0] && !portDisable[0] && curValid[0]
		&& curCount[13:0] > LIMIT_COUNT;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_read_answered: assert property (
		rdReq && !cmdValid |=> rdValid) else $error("read unanswered");
	a_no_spurious: assert property (
		!(rdReq && !cmdValid) |=> !rdValid) else $error("stray answer");
	a_data_holds: assert property (
		!rdValid |-> $stable(rdData)) else $error("data moved");
	a_reset_quiet: assert property (
		$rose(rst_n) |-> !rdValid && classScale == '0 && chanShutdown == '0)
		else $error("outputs busy after reset");
	a_class_scale: assert property (
		classValid[0] && !portDisable[0] && !curValid[0] ##1
		!portDisable[0] && !curValid[0] |=> classScale[0])
		else $error("class scale missing");
	a_scale_cause: assert property (
		$rose(classScale[0]) |-> $past(classValid[0], 2))
		else $error("class scale without class");
	a_disable_clears: assert property (
		portDisable[0] |-> ##2 !classScale[0]) else $error("scale kept");
	a_shut_rise: assert property (
		overLimit |-> ##2 chanShutdown[0]) else $error("no shutdown");
	a_shut_cause: assert property (
		$rose(chanShutdown[0]) |-> $past(overLimit, 2))
		else $error("shutdown without cause");
endmodule

bind port_telemetry_registers port_telemetry_checker #(.NCH(NCH),
	.LIMIT_COUNT(LIMIT_COUNT)) chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.cmdValid(cmdValid), .rdReq(rdReq), .rdData(rdData), .rdValid(rdValid),
	.chanOn(chanOn), .portDisable(portDisable), .curValid(curValid),
	.curCount(curCount), .classValid(classValid), .classScale(classScale),
	.chanShutdown(chanShutdown));

// File: testbench/tb.sv
// Self-checking bench for the telemetry result registers.
`timescale 1ns/100ps
module tb;
	import telemetry_pkg::*;
	localparam logic [13:0] LIM = 14'h0100;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmdValid, rdReq, rdValid, wrReq = 1'b0;
	logic [7:0] cmdCode, rdData, wrData = 8'h00;
	logic supplyValid = 1'b0, chanVoltValid = 1'b0;
	logic [13:0] supplyCount = 14'h0000, chanVoltCount = 14'h0000;
	logic [3:0] chanOn = 4'h0, detClassEn = 4'h0, portDisable = 4'h0;
	logic [3:0] curValid = 4'h0, classValid = 4'h0, classScale, chanShutdown;
	logic [55:0] curCount = 56'h0, classCount = 56'h0;
	int mismatches = 0;
	int samples_checked = 0;

	always #10 ref_clk = ~ref_clk;

	port_telemetry_registers #(.NCH(4), .LIMIT_COUNT(LIM)) uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid),
		.cmdCode(cmdCode), .rdReq(rdReq), .wrReq(wrReq), .wrData(wrData),
		.rdData(rdData), .rdValid(rdValid), .supplyValid(supplyValid),
		.supplyCount(supplyCount), .chanVoltValid(chanVoltValid),
		.chanVoltCount(chanVoltCount), .chanOn(chanOn),
		.detClassEn(detClassEn), .portDisable(portDisable),
		.curValid(curValid), .curCount(curCount), .classValid(classValid),
		.classCount(classCount), .classScale(classScale),
		.chanShutdown(chanShutdown));
	telemetry_host_model host (.ref_clk(ref_clk), .rdValid(rdValid),
		.rdData(rdData), .cmdValid(cmdValid), .cmdCode(cmdCode),
		.rdReq(rdReq));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic summarize();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic expectReg(input logic [7:0] code, input logic [15:0] exp);
		logic [15:0] v;
		logic ok;
		host.rd16(code, v, ok);
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t read timed out", $time);
			summarize();
		end
		check(v, exp);
	endtask
	task automatic classPulse(input logic [13:0] n);
		@(posedge ref_clk);
		classValid <= 4'h1;
		classCount <= {42'h0, n};
		@(posedge ref_clk);
		classValid <= 4'h0;
		repeat (2) @(posedge ref_clk);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic tReset();
		logic [7:0] codes [7] = '{8'h2E, 8'h30, 8'h32, 8'h34, 8'h38, 8'h3C,
			8'h31};
		foreach (codes[i]) expectReg(codes[i], 16'h0000);
	endtask
	task automatic tSupply();
		@(posedge ref_clk);
		supplyValid <= 1'b1;
		supplyCount <= 14'h3FFF;
		@(posedge ref_clk);
		supplyValid <= 1'b0;
		expectReg(8'h2E, 16'h3FFF);
		wrReq <= 1'b1;
		wrData <= 8'h5A;
		@(posedge ref_clk);
		wrReq <= 1'b0;
		expectReg(8'h2E, 16'h3FFF);
	endtask
	task automatic tVolt();
		@(posedge ref_clk);
		chanOn <= 4'h1;
		chanVoltValid <= 1'b1;
		chanVoltCount <= 14'h2A5C;
		@(posedge ref_clk);
		chanVoltValid <= 1'b0;
		expectReg(8'h32, 16'h2A5C);
		chanOn <= 4'h0;
		repeat (2) @(posedge ref_clk);
		expectReg(8'h32, 16'h0000);
	endtask
	task automatic tClass();
		@(posedge ref_clk);
		detClassEn <= 4'h1;
		classPulse(14'h0005);
		check({15'h0, classScale[0]}, 16'h0001);
		expectReg(8'h30, 16'h0005);
		classPulse(14'h0007);
		expectReg(8'h30, 16'h0007);
		chanOn <= 4'h1;
		curValid <= 4'h1;
		curCount <= {42'h0, 14'h0050};
		@(posedge ref_clk);
		curValid <= 4'h0;
		expectReg(8'h30, 16'h0050);
		check({15'h0, classScale[0]}, 16'h0000);
		chanOn <= 4'h0;
		classPulse(14'h0003);
		expectReg(8'h30, 16'h0003);
		portDisable <= 4'h1;
		detClassEn <= 4'h0;
		@(posedge ref_clk);
		portDisable <= 4'h0;
		expectReg(8'h30, 16'h0000);
		check({15'h0, classScale[0]}, 16'h0000);
	endtask
	task automatic tCurrents();
		logic [13:0] c [4] = '{14'h1001, 14'h2002, 14'h00FF, 14'h3FFE};
		logic [15:0] w0, w1;
		logic ok0, ok1;
		@(posedge ref_clk);
		chanOn <= 4'hF;
		curValid <= 4'hF;
		curCount <= {c[3], c[2], c[1], c[0]};
		@(posedge ref_clk);
		curValid <= 4'h0;
		for (int i = 0; i < 4; i++) begin
			expectReg(8'h30 + 8'(4 * i), {2'h0, c[i]});
		end
		check({12'h0, chanShutdown}, 16'h000B);
		host.rd16(8'h30, w0, ok0);
		host.rd16(8'h34, w1, ok1);
		if (ok0 !== 1'b1 || ok1 !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t pair read timed out", $time);
			summarize();
		end
		check(w0 + w1, {2'h0, c[0]} + {2'h0, c[1]});
		chanOn <= 4'h0;
		repeat (2) @(posedge ref_clk);
		expectReg(8'h34, 16'h0000);
	endtask

	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		tReset();
		tSupply();
		tVolt();
		tClass();
		tCurrents();
		summarize();
	end
endmodule

// File: testbench/telemetry_host_model.sv
// Management host model that reads two-byte telemetry results.
`timescale 1ns/100ps
module telemetry_host_model (
	input wire logic ref_clk,
	input wire logic rdValid,
	input wire logic [7:0] rdData,
	output logic cmdValid,
	output logic [7:0] cmdCode,
	output logic rdReq
);
	initial begin
		cmdValid = 1'b0;
		cmdCode = 8'h00;
		rdReq = 1'b0;
	end

	// One byte request; ok drops when no answer comes in time.
	task automatic rdByte(output logic [7:0] b, inout logic ok);
		int n;
		n = 0;
		@(posedge ref_clk);
		rdReq <= 1'b1;
		@(posedge ref_clk);
		rdReq <= 1'b0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rdValid !== 1'b1 && n < 4);
		if (rdValid !== 1'b1) begin
			ok = 1'b0;
		end
		b = rdData;
	endtask

	task automatic rd16(input logic [7:0] code, output logic [15:0] v,
		output logic ok);
		ok = 1'b1;
		@(posedge ref_clk);
		cmdValid <= 1'b1;
		cmdCode <= code;
		@(posedge ref_clk);
		cmdValid <= 1'b0;
		rdByte(v[7:0], ok);
		rdByte(v[15:8], ok);
	endtask
endmodule

// File: verilog/chan_current_result.sv
// Current result of one channel, with class current hold and limit check.
`timescale 1ns/100ps
`include "telemetry_params.svh"
module chan_current_result
	import telemetry_pkg::*;
#(
	parameter logic [13:0] LIMIT_COUNT = `LIMIT_COUNT_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	chan_meas_if.chan meas
);

	chan_state_t state_q;
	logic [13:0] result_q;
	logic classScale_q;
	logic shutdown_q;

	// ------------------------------------------------------------------
	// Result owner state
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= IDLE_S;
		end else if (meas.portDisable) begin
			state_q <= IDLE_S;
		end else if (meas.classValid) begin
			state_q <= CLASS_S;
		end else if (meas.curValid && meas.chanOn) begin
			state_q <= POWER_S;
		end else if (!meas.chanOn && state_q == POWER_S) begin
			state_q <= IDLE_S;
		end
	end

	// ------------------------------------------------------------------
	// Result value
	// ------------------------------------------------------------------
	// Each class finger overwrites the last, so only the final one stays.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= `RES_ZERO;
		end else if (meas.portDisable) begin
			result_q <= `RES_ZERO;
		end else if (meas.classValid) begin
			result_q <= meas.classCount;
		end else if (meas.curValid && meas.chanOn) begin
			result_q <= meas.curCount;
		end else if (!meas.chanOn && !meas.detClassEn
				&& state_q != CLASS_S) begin
			result_q <= `RES_ZERO;
		end
	end

	// ------------------------------------------------------------------
	// Scale indication and over-limit shutdown
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			classScale_q <= 1'b0;
		end else begin
			classScale_q <= (meas.portDisable == 1'b0)
				&& (meas.classValid
				|| (state_q == CLASS_S
				&& !(meas.curValid && meas.chanOn)));
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shutdown_q <= 1'b0;
		end else if (!meas.chanOn || meas.portDisable) begin
			shutdown_q <= 1'b0;
		end else if (meas.curValid && meas.curCount > LIMIT_COUNT) begin
			shutdown_q <= 1'b1;
		end
	end

	assign meas.result = result_q;
	assign meas.classScale = classScale_q;
	assign meas.shutdown = shutdown_q;

endmodule

// File: verilog/port_telemetry_registers.sv
// Read-only telemetry result registers reached by management commands.
`timescale 1ns/100ps
`include "telemetry_params.svh"
module port_telemetry_registers
	import telemetry_pkg::*;
#(
	parameter int NCH = `CHAN_COUNT,
	parameter logic [13:0] LIMIT_COUNT = `LIMIT_COUNT_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cmdValid,
	input wire logic [7:0] cmdCode,
	input wire logic rdReq,
	input wire logic wrReq,
	input wire logic [7:0] wrData,
	output logic [7:0] rdData,
	output logic rdValid,
	input wire logic supplyValid,
	input wire logic [13:0] supplyCount,
	input wire logic chanVoltValid,
	input wire logic [13:0] chanVoltCount,
	input wire logic [NCH-1:0] chanOn,
	input wire logic [NCH-1:0] detClassEn,
	input wire logic [NCH-1:0] portDisable,
	input wire logic [NCH-1:0] curValid,
	input wire logic [NCH*14-1:0] curCount,
	input wire logic [NCH-1:0] classValid,
	input wire logic [NCH*14-1:0] classCount,
	output logic [NCH-1:0] classScale,
	output logic [NCH-1:0] chanShutdown
);

	// ------------------------------------------------------------------
	// Stored results
	// ------------------------------------------------------------------
	logic [13:0] supplyVolt_q;
	logic [13:0] chanVolt_q;
	logic [13:0] curResult [NCH];
	logic [NCH-1:0] scaleNow;
	logic [NCH-1:0] shutNow;
	logic [NCH-1:0] classScale_q;
	logic [NCH-1:0] chanShutdown_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			supplyVolt_q <= `RES_ZERO;
		end else if (supplyValid) begin
			supplyVolt_q <= supplyCount;
		end
	end

	// The stored value is cleared as the channel goes off, so a later
	// turn-on never shows a stale voltage before the first new sample.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			chanVolt_q <= `RES_ZERO;
		end else if (!chanOn[0]) begin
			chanVolt_q <= `RES_ZERO;
		end else if (chanVoltValid) begin
			chanVolt_q <= chanVoltCount;
		end
	end

	// ------------------------------------------------------------------
	// Channel current results
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_chan
			chan_meas_if link ();

			assign link.chanOn = chanOn[gi];
			assign link.detClassEn = detClassEn[gi];
			assign link.portDisable = portDisable[gi];
			assign link.curValid = curValid[gi];
			assign link.curCount = curCount[gi*`RES_WIDTH +: `RES_WIDTH];
			assign link.classValid = classValid[gi];
			assign link.classCount = classCount[gi*`RES_WIDTH +: `RES_WIDTH];
			assign curResult[gi] = link.result;
			assign scaleNow[gi] = link.classScale;
			assign shutNow[gi] = link.shutdown;

			chan_current_result #(
				.LIMIT_COUNT(LIMIT_COUNT)
			) u_chan (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.meas(link.chan)
			);
		end
	endgenerate

	// Both flags pass one more flop, so that every output of the bank
	// comes straight from a register.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			classScale_q <= '0;
		end else begin
			classScale_q <= scaleNow;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			chanShutdown_q <= '0;
		end else begin
			chanShutdown_q <= shutNow;
		end
	end

	assign classScale = classScale_q;
	assign chanShutdown = chanShutdown_q;

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	logic [7:0] cmd_q;
	byte_sel_t byteSel_q;
	logic [7:0] highSnap_q;
	logic [15:0] selWord;
	logic [7:0] chanCode;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= `BYTE_ZERO;
		end else if (cmdValid) begin
			cmd_q <= cmdCode;
		end
	end

	// Unmapped codes answer with zero bytes.
	always_comb begin
		selWord = {`HIGH_PAD, `RES_ZERO};
		chanCode = `CMD_CHAN1_CURRENT;
		if (cmd_q == `CMD_SUPPLY_VOLTAGE) begin
			selWord = {`HIGH_PAD, supplyVolt_q};
		end else if (cmd_q == `CMD_CHAN1_VOLTAGE) begin
			selWord = {`HIGH_PAD, chanVolt_q};
		end else begin
			for (int i = 0; i < NCH; i++) begin
				chanCode = 8'(`CMD_CHAN1_CURRENT
					+ i * `CMD_CURRENT_STRIDE);
				if (cmd_q == chanCode) begin
					selWord = {`HIGH_PAD, curResult[i]};
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Byte delivery
	// ------------------------------------------------------------------
	logic readTake;
	assign readTake = rdReq && !cmdValid;

	// The high byte is captured with the low byte, so a result that
	// updates between the two reads is never torn.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			byteSel_q <= LOW_SEL;
		end else if (cmdValid) begin
			byteSel_q <= LOW_SEL;
		end else if (rdReq) begin
			byteSel_q <= (byteSel_q == LOW_SEL) ? HIGH_SEL : LOW_SEL;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			highSnap_q <= `BYTE_ZERO;
		end else if (readTake && byteSel_q == LOW_SEL) begin
			highSnap_q <= selWord[15:`HIGH_BYTE_LSB];
		end
	end

	// ------------------------------------------------------------------
	// Answer to the host
	// ------------------------------------------------------------------
	// A read in the same cycle as a command is refused, so no answer can
	// carry a byte of the register that is just being replaced.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdValid <= 1'b0;
		end else begin
			rdValid <= readTake;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData <= `BYTE_ZERO;
		end else if (readTake) begin
			if (byteSel_q == LOW_SEL) begin
				rdData <= selWord[`LOW_BYTE_MSB:0];
			end else begin
				rdData <= highSnap_q;
			end
		end
	end

	// ------------------------------------------------------------------
	// Write requests
	// ------------------------------------------------------------------
	// Writes reach no storage at all; the bank is read-only.
	logic unusedWrite;
	assign unusedWrite = wrReq ^ (^wrData);

endmodule
